// ===== core/rpsm_pkg.sv
// Package: register map, field layout and reset values of the pin select matrix
package rpsm_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int RPSM_DATA_W = 16;  // Register width
  localparam int RPSM_ADDR_W = 4;   // Register index width
  localparam int RPSM_SEL_W = 5;    // Width of every select field
  localparam int RPSM_NUM_PINS = 32;  // Pins / functions a 5-bit field can name
  localparam int RPSM_OUT_PINS = 8;   // Remappable pins driven here

  // ---------------------------------------------------------------
  // Register indices (word addresses on the register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] RPSM_UART2_IN_IDX = 4'h0;
  localparam logic [3:0] RPSM_SPI1_CD_IN_IDX = 4'h1;
  localparam logic [3:0] RPSM_SPI1_SS_IN_IDX = 4'h2;
  localparam logic [3:0] RPSM_SPI2_CD_IN_IDX = 4'h3;
  localparam logic [3:0] RPSM_SPI2_SS_IN_IDX = 4'h4;
  localparam logic [3:0] RPSM_PIN01_OUT_IDX = 4'h5;
  localparam logic [3:0] RPSM_PIN23_OUT_IDX = 4'h6;
  localparam logic [3:0] RPSM_PIN45_OUT_IDX = 4'h7;
  localparam logic [3:0] RPSM_PIN67_OUT_IDX = 4'h8;

  // ---------------------------------------------------------------
  // Field positions (low bit of each field)
  // ---------------------------------------------------------------
  localparam int RPSM_LO_FIELD_POS = 0;  // Bits 4..0
  localparam int RPSM_HI_FIELD_POS = 8;  // Bits 12..8

  // ---------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RPSM_MASK_TWO = 16'h1f1f;  // Two-field register
  localparam logic [15:0] RPSM_MASK_ONE = 16'h001f;  // One-field register
  localparam logic [4:0] RPSM_IN_SEL_RST = 5'h1f;    // Input select at reset
  localparam logic [4:0] RPSM_OUT_SEL_RST = 5'h00;   // Output select at reset
  localparam logic [15:0] RPSM_READ_ZERO = 16'h0000;  // Unmapped / unimplemented

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rpsm_bus_req_t;

  typedef struct packed {
    logic uart2_receive;
    logic uart2_clear_to_send;
    logic spi1_clock_in;
    logic spi1_data_in;
    logic spi1_select_in;
    logic spi2_clock_in;
    logic spi2_data_in;
    logic spi2_select_in;
  } rpsm_periph_in_t;

endpackage

// ===== core/rpsm_matrix.sv
// Remappable pin select matrix: select registers, input and output routing
//
// Function
// - Reg 19 bits 12:8 pick UART2 CTS pin
// - Reg 19 bits 4:0 pick UART2 RX pin
// - Reg 20 bits 12:8 pick SPI1 clock pin
// - Reg 20 bits 4:0 pick SPI1 data pin
// - Reg 21 bits 4:0 pick SPI1 select pin
// - Reg 22 bits 12:8 pick SPI2 clock pin
// - Reg 22 bits 4:0 pick SPI2 data pin
// - Reg 23 bits 4:0 pick SPI2 select pin
// - Output reg 0 low field drives pin 0
// - Output reg 0 high field drives pin 1
// - Output reg 1 fields drive pins 2, 3
// - Output reg 2 fields drive pins 4, 5
// - Output reg 3 fields drive pins 6, 7
// - Unimplemented bits ignore writes, read zero
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps

module rpsm_matrix
  import rpsm_pkg::*;
#(
  parameter int NUM_PINS = RPSM_NUM_PINS  // Remappable pins / function numbers
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire rpsm_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  // Remappable pin levels and peripheral output functions
  input wire logic [NUM_PINS-1:0] remappable_io_pin,
  input wire logic [NUM_PINS-1:0] periph_out_func,
  // Routed peripheral inputs
  output wire rpsm_periph_in_t periph_in,
  // Remappable pin 0..7 output levels; nets, since each member has its own assign
  output wire logic [RPSM_OUT_PINS-1:0] pin_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Pick one line of a pin/function vector by a 5-bit number
  function automatic logic pick(input logic [NUM_PINS-1:0] vec, input logic [4:0] sel);
    logic [31:0] wide;
    wide = 32'h0000_0000;
    wide[NUM_PINS-1:0] = vec;
    return wide[sel];  // Numbers past NUM_PINS read as zero
  endfunction

  // Next value of a register under a masked write
  function automatic logic [15:0] upd(input logic [15:0] cur, input logic hit,
                                      input logic [15:0] wd, input logic [15:0] mask);
    return hit ? (wd & mask) : cur;  // Masked bits never store
  endfunction

  // ---------------------------------------------------------------
  // Select registers (all 16 bits declared as flops; unimplemented bits stay zero)
  // ---------------------------------------------------------------
  logic [15:0] uart2_input_select_r;          // CTS 12:8, RX 4:0
  logic [15:0] spi1_clock_data_input_select_r;  // Clock 12:8, data 4:0
  logic [15:0] spi1_select_input_select_r;    // Select 4:0
  logic [15:0] spi2_clock_data_input_select_r;  // Clock 12:8, data 4:0
  logic [15:0] spi2_select_input_select_r;    // Select 4:0
  logic [15:0] pin0_pin1_output_select_r;     // Pin 1 12:8, pin 0 4:0
  logic [15:0] pin2_pin3_output_select_r;
  logic [15:0] pin4_pin5_output_select_r;
  logic [15:0] pin6_pin7_output_select_r;
  logic [15:0] bus_rdata_r;                   // Read data, valid one cycle
  logic [15:0] rdata_nxt;                     // Selected read word

  // Reset words built from the field reset values
  localparam logic [15:0] IN_RST_TWO = {3'b000, RPSM_IN_SEL_RST, 3'b000, RPSM_IN_SEL_RST};
  localparam logic [15:0] IN_RST_ONE = {11'h000, RPSM_IN_SEL_RST};
  localparam logic [15:0] OUT_RST = {3'b000, RPSM_OUT_SEL_RST, 3'b000, RPSM_OUT_SEL_RST};

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic wr_uart2 = bus_req.wr && (bus_req.addr == RPSM_UART2_IN_IDX);
  wire logic wr_spi1_cd = bus_req.wr && (bus_req.addr == RPSM_SPI1_CD_IN_IDX);
  wire logic wr_spi1_ss = bus_req.wr && (bus_req.addr == RPSM_SPI1_SS_IN_IDX);
  wire logic wr_spi2_cd = bus_req.wr && (bus_req.addr == RPSM_SPI2_CD_IN_IDX);
  wire logic wr_spi2_ss = bus_req.wr && (bus_req.addr == RPSM_SPI2_SS_IN_IDX);
  wire logic wr_pin01 = bus_req.wr && (bus_req.addr == RPSM_PIN01_OUT_IDX);
  wire logic wr_pin23 = bus_req.wr && (bus_req.addr == RPSM_PIN23_OUT_IDX);
  wire logic wr_pin45 = bus_req.wr && (bus_req.addr == RPSM_PIN45_OUT_IDX);
  wire logic wr_pin67 = bus_req.wr && (bus_req.addr == RPSM_PIN67_OUT_IDX);

  // Read mux; unmapped indices answer zero
  always_comb begin
    unique case (bus_req.addr)
      RPSM_UART2_IN_IDX: rdata_nxt = uart2_input_select_r;
      RPSM_SPI1_CD_IN_IDX: rdata_nxt = spi1_clock_data_input_select_r;
      RPSM_SPI1_SS_IN_IDX: rdata_nxt = spi1_select_input_select_r;
      RPSM_SPI2_CD_IN_IDX: rdata_nxt = spi2_clock_data_input_select_r;
      RPSM_SPI2_SS_IN_IDX: rdata_nxt = spi2_select_input_select_r;
      RPSM_PIN01_OUT_IDX: rdata_nxt = pin0_pin1_output_select_r;
      RPSM_PIN23_OUT_IDX: rdata_nxt = pin2_pin3_output_select_r;
      RPSM_PIN45_OUT_IDX: rdata_nxt = pin4_pin5_output_select_r;
      RPSM_PIN67_OUT_IDX: rdata_nxt = pin6_pin7_output_select_r;
      default: rdata_nxt = RPSM_READ_ZERO;
    endcase
  end

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------

  // Input select registers; reset to all-ones fields
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      uart2_input_select_r <= IN_RST_TWO;
      spi1_clock_data_input_select_r <= IN_RST_TWO;
      spi1_select_input_select_r <= IN_RST_ONE;
      spi2_clock_data_input_select_r <= IN_RST_TWO;
      spi2_select_input_select_r <= IN_RST_ONE;
    end else begin
      uart2_input_select_r <= upd(uart2_input_select_r, wr_uart2, bus_req.wdata,
                                  RPSM_MASK_TWO);
      spi1_clock_data_input_select_r <= upd(spi1_clock_data_input_select_r, wr_spi1_cd,
                                            bus_req.wdata, RPSM_MASK_TWO);
      spi1_select_input_select_r <= upd(spi1_select_input_select_r, wr_spi1_ss,
                                        bus_req.wdata, RPSM_MASK_ONE);
      spi2_clock_data_input_select_r <= upd(spi2_clock_data_input_select_r, wr_spi2_cd,
                                            bus_req.wdata, RPSM_MASK_TWO);
      spi2_select_input_select_r <= upd(spi2_select_input_select_r, wr_spi2_ss,
                                        bus_req.wdata, RPSM_MASK_ONE);
    end
  end

  // Output select registers; reset to function zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin0_pin1_output_select_r <= OUT_RST;
      pin2_pin3_output_select_r <= OUT_RST;
      pin4_pin5_output_select_r <= OUT_RST;
      pin6_pin7_output_select_r <= OUT_RST;
    end else begin
      pin0_pin1_output_select_r <= upd(pin0_pin1_output_select_r, wr_pin01,
                                       bus_req.wdata, RPSM_MASK_TWO);
      pin2_pin3_output_select_r <= upd(pin2_pin3_output_select_r, wr_pin23,
                                       bus_req.wdata, RPSM_MASK_TWO);
      pin4_pin5_output_select_r <= upd(pin4_pin5_output_select_r, wr_pin45,
                                       bus_req.wdata, RPSM_MASK_TWO);
      pin6_pin7_output_select_r <= upd(pin6_pin7_output_select_r, wr_pin67,
                                       bus_req.wdata, RPSM_MASK_TWO);
    end
  end

  // Read data register; held at zero between reads so stale words never linger
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata_r <= RPSM_READ_ZERO;
    end else begin
      bus_rdata_r <= bus_req.rd ? rdata_nxt : RPSM_READ_ZERO;
    end
  end

  assign bus_rdata = bus_rdata_r;

  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  wire logic [4:0] uart2_cts_source_sel =
    uart2_input_select_r[RPSM_HI_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] uart2_rx_source_sel =
    uart2_input_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] spi1_clk_source_sel =
    spi1_clock_data_input_select_r[RPSM_HI_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] spi1_din_source_sel =
    spi1_clock_data_input_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] spi1_select_source_sel =
    spi1_select_input_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] spi2_clk_source_sel =
    spi2_clock_data_input_select_r[RPSM_HI_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] spi2_din_source_sel =
    spi2_clock_data_input_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] spi2_select_source_sel =
    spi2_select_input_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];

  // Output select fields, pin order 0..7
  wire logic [4:0] pin0_func_sel = pin0_pin1_output_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] pin1_func_sel = pin0_pin1_output_select_r[RPSM_HI_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] pin2_func_sel = pin2_pin3_output_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] pin3_func_sel = pin2_pin3_output_select_r[RPSM_HI_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] pin4_func_sel = pin4_pin5_output_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] pin5_func_sel = pin4_pin5_output_select_r[RPSM_HI_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] pin6_func_sel = pin6_pin7_output_select_r[RPSM_LO_FIELD_POS +: RPSM_SEL_W];
  wire logic [4:0] pin7_func_sel = pin6_pin7_output_select_r[RPSM_HI_FIELD_POS +: RPSM_SEL_W];

  // ---------------------------------------------------------------
  // Routing: pure combinational from the registers, so a write is
  // felt the cycle after it; pin levels pass with no added latency
  // ---------------------------------------------------------------
  assign periph_in.uart2_clear_to_send = pick(remappable_io_pin, uart2_cts_source_sel);
  assign periph_in.uart2_receive = pick(remappable_io_pin, uart2_rx_source_sel);
  assign periph_in.spi1_clock_in = pick(remappable_io_pin, spi1_clk_source_sel);
  assign periph_in.spi1_data_in = pick(remappable_io_pin, spi1_din_source_sel);
  assign periph_in.spi1_select_in = pick(remappable_io_pin, spi1_select_source_sel);
  assign periph_in.spi2_clock_in = pick(remappable_io_pin, spi2_clk_source_sel);
  assign periph_in.spi2_data_in = pick(remappable_io_pin, spi2_din_source_sel);
  assign periph_in.spi2_select_in = pick(remappable_io_pin, spi2_select_source_sel);

  // Pin outputs; function zero is whatever the peripheral table puts there
  assign pin_out[0] = pick(periph_out_func, pin0_func_sel);
  assign pin_out[1] = pick(periph_out_func, pin1_func_sel);
  assign pin_out[2] = pick(periph_out_func, pin2_func_sel);
  assign pin_out[3] = pick(periph_out_func, pin3_func_sel);
  assign pin_out[4] = pick(periph_out_func, pin4_func_sel);
  assign pin_out[5] = pick(periph_out_func, pin5_func_sel);
  assign pin_out[6] = pick(periph_out_func, pin6_func_sel);
  assign pin_out[7] = pick(periph_out_func, pin7_func_sel);

endmodule

// ===== verification/rpsm_far_model.sv
// Far-side model: remappable pin levels and peripheral output levels
`timescale 1ns/1ps

module rpsm_far_model #(
  parameter int NUM_PINS = 32  // Pins and function numbers
) (
  // Pattern chosen by the bench
  input wire logic [NUM_PINS-1:0] pat,
  // Levels seen by the matrix
  output logic [NUM_PINS-1:0] remappable_io_pin,
  output logic [NUM_PINS-1:0] periph_out_func
);
  // Functions carry the inverse, so a matrix stuck at 0 or 1 shows on one side
  assign remappable_io_pin = pat;
  assign periph_out_func = ~pat;
endmodule

// ===== verification/rpsm_matrix_monitor.sv
// Checker: register port and routing relations of the pin select matrix
`timescale 1ns/1ps

module rpsm_monitor
  import rpsm_pkg::*;
#(
  parameter int NUM_PINS = 32  // Pins and function numbers
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire rpsm_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  // Pins and routed signals
  input wire logic [NUM_PINS-1:0] remappable_io_pin,
  input wire logic [NUM_PINS-1:0] periph_out_func,
  input wire rpsm_periph_in_t periph_in,
  input wire logic [RPSM_OUT_PINS-1:0] pin_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Access steps on the pin 0/1 register
  // ----------------------------------------
  sequence wr_pin01;
    bus_req.wr && bus_req.addr == 4'h5;
  endsequence
  sequence rd_pin01;
    bus_req.rd && bus_req.addr == 4'h5;
  endsequence
  // Read data only after a read, zero elsewhere
  idle_read_a: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not zero after idle cycle");
  unimpl_zero_a: assert property ((bus_rdata & 16'he0e0) == 16'h0000)
    else $error("unimplemented bits read as one");
  one_field_a: assert property (bus_req.rd && (bus_req.addr == 4'h2 || bus_req.addr == 4'h4)
    |=> bus_rdata[15:5] == 11'h000) else $error("single-field register upper bits set");
  unmapped_zero_a: assert property (bus_req.rd && bus_req.addr > 4'h8 |=> bus_rdata == 16'h0000)
    else $error("unmapped index read not zero");
  write_back_a: assert property (wr_pin01 ##1 rd_pin01
    |=> bus_rdata == ($past(bus_req.wdata, 2) & 16'h1f1f)) else $error("readback mismatch");
  pin0_route_a: assert property (wr_pin01
    |=> pin_out[0] == periph_out_func[$past(bus_req.wdata[4:0])]) else $error("pin 0 route");
  pin1_route_a: assert property (wr_pin01
    |=> pin_out[1] == periph_out_func[$past(bus_req.wdata[12:8])]) else $error("pin 1 route");
  uart_route_a: assert property (bus_req.wr && bus_req.addr == 4'h0 |=>
    periph_in.uart2_receive == remappable_io_pin[$past(bus_req.wdata[4:0])] &&
    periph_in.uart2_clear_to_send == remappable_io_pin[$past(bus_req.wdata[12:8])])
    else $error("uart2 input route");
  spi2_sel_a: assert property (bus_req.wr && bus_req.addr == 4'h4
    |=> periph_in.spi2_select_in == remappable_io_pin[$past(bus_req.wdata[4:0])])
    else $error("spi2 select route");
  reset_route_a: assert property ($rose(reset_n) |-> pin_out == {8{periph_out_func[0]}} &&
    periph_in.spi1_clock_in == remappable_io_pin[31]) else $error("reset routing wrong");
endmodule

bind rpsm_matrix rpsm_monitor #(.NUM_PINS(NUM_PINS)) u_rpsm_monitor (.sys_clk(sys_clk),
  .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .remappable_io_pin(remappable_io_pin), .periph_out_func(periph_out_func),
  .periph_in(periph_in), .pin_out(pin_out));

// ===== verification/tb_rpsm_matrix.sv
// Testbench: register access, reset values and routing of the pin select matrix
`timescale 1ns/1ps

module tb_rpsm_matrix
  import rpsm_pkg::*;
;
  logic sys_clk = 1'b0;  // 100 MHz clock
  logic reset_n = 1'b0;  // Held low at start
  rpsm_bus_req_t bus_req = '0;
  logic [15:0] bus_rdata;
  logic [31:0] pat = 32'h8000_0001;  // Far-side pattern
  logic [31:0] remappable_io_pin;
  logic [31:0] periph_out_func;
  rpsm_periph_in_t periph_in;
  logic [7:0] pin_out;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] got;
  logic [4:0] n;
  logic [4:0] m;
  logic [15:0] word;
  logic [3:0] in_idx [8] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h3, 4'h4};
  bit in_hi [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  rpsm_matrix #(.NUM_PINS(32)) u_rpsm_matrix (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .remappable_io_pin(remappable_io_pin),
    .periph_out_func(periph_out_func), .periph_in(periph_in), .pin_out(pin_out));
  rpsm_far_model #(.NUM_PINS(32)) u_rpsm_far_model (.pat(pat),
    .remappable_io_pin(remappable_io_pin), .periph_out_func(periph_out_func));

  always #5 sys_clk = ~sys_clk;
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  // One request per edge; never lowered inside, so back-to-back calls stay clean
  task automatic put(input logic [3:0] a, input logic [15:0] d, input logic w);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
  endtask
  // Release the port one edge later and let that edge settle
  task automatic settle();
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    put(a, 16'h0000, 1'b0);
    settle();
    q = bus_rdata;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Implemented bits per register index
  function automatic logic [15:0] mask(input int i);
    return (i == 2 || i == 4) ? 16'h001f : (i < 9 ? 16'h1f1f : 16'h0000);
  endfunction
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    chk({8'h00, periph_in}, 16'h00ff);
    chk({8'h00, pin_out}, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), got);
      chk(got, i < 5 ? mask(i) : 16'h0000);
    end
    // All ones written back to back, unmapped indices among them
    for (int i = 0; i < 16; i++) put(4'(i), 16'hffff, 1'b1);
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), got);
      chk(got, mask(i));
    end
    // Each routed input: its own field selects, the neighbour field does not
    for (int i = 0; i < 8; i++) begin
      n = 5'(3 * i + 2);
      m = ~n;
      word = in_hi[i] ? {3'b000, n, 3'b000, m} : {3'b000, m, 3'b000, n};
      put(in_idx[i], word, 1'b1);
      settle();
      @(posedge sys_clk);
      pat <= 32'h0000_0001 << n;
      #1 chk({15'h0000, periph_in[7-i]}, 16'h0001);
      @(posedge sys_clk);
      pat <= 32'h0000_0001 << m;
      #1 chk({15'h0000, periph_in[7-i]}, 16'h0000);
    end
    // Output pins in pairs, read back right after the write
    for (int j = 0; j < 4; j++) begin
      n = 5'(4 * j + 1);
      m = 5'(30 - 4 * j);
      put(4'(5 + j), {3'b111, m, 3'b111, n}, 1'b1);
      rd(4'(5 + j), got);
      chk(got, {3'b000, m, 3'b000, n});
      @(posedge sys_clk);
      pat <= 32'h0000_0001 << n;
      #1 chk({14'h0000, pin_out[2*j+1 -: 2]}, 16'h0002);
      @(posedge sys_clk);
      pat <= 32'h0000_0001 << m;
      #1 chk({14'h0000, pin_out[2*j+1 -: 2]}, 16'h0001);
    end
    summarize();
  end
endmodule
